// ---- hdl/ats_seq.sv ----
// Transfer switch sequencer: source qualification, delays, lamps, APB
`timescale 1ns/1ps
`include "ats_seq_cfg.svh"
// Overview of operation
// RL1 - Available latches on only when all enabled pickup conditions hold
// RL2 - Available drops only after a dropout condition outlasts its delay
// RL3 - Pickup needs every phase above; dropout starts on any phase below
// RL4 - Undervoltage dropout delay is fixed at half a second
// RL5 - Undervoltage pickup 85-100 percent, dropout 75-98 percent of pickup
// RL6 - Overvoltage limit 105-135 percent, pickup 5 below, delay 0-120 s
// RL7 - Frequency pickup band 5-20 percent, dropout band 5 percent wider
// RL8 - Frequency dropout delay adjustable from 0 to 15 s
// RL9 - Source one loss runs start delay 0-15 s, then generator start
// RL10 - Extended start delay option reaches 90 s
// RL11 - Utility-to-utility uses no start and no stop delay
// RL12 - Source two available runs transfer delay 0-120 s, then transfer
// RL13 - With both available, act for preferred source
// RL14 - Source one return runs retransfer delay 0-30 min, then retransfer
// RL15 - Retransfer starts stop delay 0-10 min, then generator stops
// RL16 - Stop lamp lit while timing; expiry clears stop and run lamps
// RL17 - Retransfer lamp lit while timing; expiry lights retransfer complete
// RL18 - Transfer lamp lit while timing; expiry lights transfer complete
// RL19 - Generator run lamp lit while generator run is commanded
// RL20 - Each source lamp follows that source's available indication
// RL21 - Generator pair mode gives separate start outputs per generator
// RL22 - Start, available, transfer, retransfer, backup failure exported
// RL23 - Open transfer inhibit makes source two unavailable
// RL24 - Instant retransfer skips the retransfer delay
// RL25 - Delays count ticks of a clock-derived time base
// RL26 - Reset clears timers, commands and available indications
module ats_seq #(
  parameter int TICK_CYCLES = `TICK_CYC
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Source sensors and panel inputs, asynchronous
  input  wire ats_seq_pkg::sense_t [1:0] sense_in,
  input  wire logic                      inhibit_open,
  input  wire logic                      instant_retx,
  input  wire logic                      pref_sel,
  // Generator, transfer relays, option modules
  output logic      [1:0]                gen_start,
  output logic                           xfer_cmd,
  output logic                           retx_cmd,
  output logic                           backup_fail,
  output logic      [1:0]                src_avail,
  output ats_seq_pkg::lamp_t             lamps,
  output ats_seq_pkg::thresh_t           thresh
);
  localparam int TW = 16;

  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input int lo, input int hi);
    if (int'(v) < lo) clamp8 = 8'(lo);
    else if (int'(v) > hi) clamp8 = 8'(hi);
    else clamp8 = v;
  endfunction : clamp8

  function automatic logic [TW-1:0] secs(input logic [10:0] s);
    secs = TW'(int'(s) * `TICKS_PER_S);
  endfunction : secs

  logic [31:0] ctrl, sense_cfg, dly_a, dly_b;
  ats_seq_pkg::sense_t [1:0] sense_m, sense_s;
  logic [2:0] pin_m, pin_s;
  logic [31:0] tick_cnt;
  logic tick;
  logic [1:0] avail, pick_ok, drop_exp;
  logic [TW-1:0] dcnt [2][3];
  logic [2:0] dcond_all [2];
  logic [TW-1:0] dlim [3];
  ats_seq_pkg::state_t state, next_state;
  logic [TW-1:0] seq_cnt, seq_lim;
  logic seq_exp, gen_run, xfer_done, retx_done;
  logic pref, nrm_av, alt_av, src2_ok;
  ats_seq_pkg::mode_t mode;
  logic [2:0] ph_mask;
  logic wr, rd_hit;

  assign mode = ats_seq_pkg::mode_t'(ctrl[`F_MODE_LO +: 2]);
  assign ph_mask = ctrl[`F_ONE_PHASE] ? 3'h1 : 3'h7;

  // Two flops on every sensor and panel pin before any logic reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_m <= '0;
      sense_s <= '0;
      pin_m   <= 3'h0;
      pin_s   <= 3'h0;
    end else begin
      sense_m <= sense_in;
      sense_s <= sense_m;
      pin_m   <= {pref_sel, instant_retx, inhibit_open};
      pin_s   <= pin_m;
    end
  end

  // RL25 time base tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt <= 32'h0;
    else if (tick) tick_cnt <= 32'h0;
    else tick_cnt <= tick_cnt + 32'h1;
  end
  assign tick = (tick_cnt >= 32'(TICK_CYCLES - 1));

  // RL4 fixed undervoltage delay, RL6 RL8 adjustable delays
  assign dlim[0] = TW'(`UV_DROP_TICKS);
  assign dlim[1] = secs({3'h0, dly_a[`F_OV_LO +: 8]});
  assign dlim[2] = secs({3'h0, dly_a[`F_FR_LO +: 8]});

  always_comb begin
    for (int s = 0; s < 2; s++) begin
      // RL3 all phases for pickup, any phase for dropout
      dcond_all[s][0] = ctrl[`F_EN_LO] &
                        (|(sense_s[s].uv_below_drop & ph_mask));
      dcond_all[s][1] = ctrl[`F_EN_LO+1] & sense_s[s].ov_over;
      dcond_all[s][2] = ctrl[`F_EN_LO+2] & sense_s[s].fr_out_drop;
      pick_ok[s] =
        (!ctrl[`F_EN_LO] |
         (&(sense_s[s].uv_above_pick | ~ph_mask))) &
        (!ctrl[`F_EN_LO+1] | sense_s[s].ov_below_pick) &
        (!ctrl[`F_EN_LO+2] | sense_s[s].fr_in_pick);
      drop_exp[s] = 1'b0;
      for (int c = 0; c < 3; c++) begin
        if (dcond_all[s][c] && dcnt[s][c] >= dlim[c]) drop_exp[s] = 1'b1;
      end
    end
  end

  // RL2 dropout persistence counters, cleared when the condition clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < 2; s++)
        for (int c = 0; c < 3; c++) dcnt[s][c] <= '0;
    end else begin
      for (int s = 0; s < 2; s++)
        for (int c = 0; c < 3; c++)
          if (!dcond_all[s][c]) dcnt[s][c] <= '0;
          else if (tick && dcnt[s][c] != '1)
            dcnt[s][c] <= dcnt[s][c] + TW'(1);
    end
  end

  // RL1 latch on pickup, RL2 release on expired dropout, RL26 reset off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) avail <= 2'h0;
    else begin
      for (int s = 0; s < 2; s++) begin
        if (avail[s] && drop_exp[s]) avail[s] <= 1'b0;
        else if (!avail[s] && pick_ok[s] && !drop_exp[s]) avail[s] <= 1'b1;
      end
    end
  end

  // RL23 inhibit hides source two
  assign src2_ok = avail[1] & !pin_s[0];
  // RL13 preferred source choice
  assign pref   = (mode == ats_seq_pkg::MODE_UTIL_GEN) ? 1'b0 : pin_s[2];
  assign nrm_av = pref ? src2_ok : avail[0];
  assign alt_av = pref ? avail[0] : src2_ok;

  // Delay for the running sequence step
  always_comb begin
    seq_lim = '0;
    case (state)
      // RL9 RL10 start delay, RL11 none between utilities
      ats_seq_pkg::ST_START: begin
        if (mode != ats_seq_pkg::MODE_UTIL_UTIL)
          seq_lim = secs({3'h0, dly_a[`F_START_LO +: 8]});
      end
      // RL12 transfer delay
      ats_seq_pkg::ST_XFER: seq_lim = secs({3'h0, dly_a[`F_XFER_LO +: 8]});
      // RL14 retransfer delay
      ats_seq_pkg::ST_RETX: seq_lim = secs(dly_b[`F_RETX_LO +: 11]);
      // RL15 stop delay, RL11 none between utilities
      ats_seq_pkg::ST_STOP: begin
        if (mode != ats_seq_pkg::MODE_UTIL_UTIL)
          seq_lim = secs({1'b0, dly_b[`F_STOP_LO +: 10]});
      end
      default: seq_lim = '0;
    endcase
  end
  assign seq_exp = (seq_cnt >= seq_lim);

  always_comb begin
    next_state = state;
    case (state)
      ats_seq_pkg::ST_NORMAL: if (!nrm_av) next_state = ats_seq_pkg::ST_START;
      // RL9 abort on return, start generator on expiry
      ats_seq_pkg::ST_START: begin
        if (nrm_av) next_state = ats_seq_pkg::ST_NORMAL;
        else if (seq_exp) next_state = ats_seq_pkg::ST_XFER;
      end
      ats_seq_pkg::ST_XFER: begin
        if (nrm_av) next_state = ats_seq_pkg::ST_STOP;
        else if (alt_av && seq_exp) next_state = ats_seq_pkg::ST_ALT;
      end
      ats_seq_pkg::ST_ALT: if (nrm_av) next_state = ats_seq_pkg::ST_RETX;
      // RL24 instant retransfer; a failed backup also skips the wait
      ats_seq_pkg::ST_RETX: begin
        if (!nrm_av) next_state = ats_seq_pkg::ST_ALT;
        else if (seq_exp || pin_s[1] || !alt_av)
          next_state = ats_seq_pkg::ST_STOP;
      end
      ats_seq_pkg::ST_STOP: begin
        if (!nrm_av) next_state = ats_seq_pkg::ST_XFER;
        else if (seq_exp) next_state = ats_seq_pkg::ST_NORMAL;
      end
      default: next_state = ats_seq_pkg::ST_NORMAL;
    endcase
  end

  // RL26 sequence timer and state clear on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ats_seq_pkg::ST_NORMAL;
      seq_cnt <= '0;
    end else begin
      state <= next_state;
      // Timer restarts on each state change and holds at zero in transfer while the alternate source is down
      if (next_state != state) seq_cnt <= '0;
      else if (state == ats_seq_pkg::ST_XFER && !alt_av) seq_cnt <= '0;
      else if (tick && seq_cnt != '1) seq_cnt <= seq_cnt + TW'(1);
    end
  end

  // RL18 lamp latches at transfer delay expiry, RL17 lamp whenever retransfer moves on to stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_done <= 1'b0;
      retx_done <= 1'b0;
    end else if (next_state == ats_seq_pkg::ST_ALT &&
                 state == ats_seq_pkg::ST_XFER) begin
      xfer_done <= 1'b1;
      retx_done <= 1'b0;
    end else if (next_state == ats_seq_pkg::ST_STOP &&
                 state == ats_seq_pkg::ST_RETX) begin
      xfer_done <= 1'b0;
      retx_done <= 1'b1;
    end
  end

  assign gen_run = (state == ats_seq_pkg::ST_XFER) ||
                   (state == ats_seq_pkg::ST_ALT)  ||
                   (state == ats_seq_pkg::ST_RETX) ||
                   (state == ats_seq_pkg::ST_STOP);

  // Outputs are one flop behind the state they show
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_start   <= 2'h0;
      xfer_cmd    <= 1'b0;
      retx_cmd    <= 1'b0;
      backup_fail <= 1'b0;
      src_avail   <= 2'h0;
      lamps       <= '0;
    end else begin
      // RL21 per-generator start in generator pair mode
      if (mode == ats_seq_pkg::MODE_GEN_GEN)
        gen_start <= gen_run ? (pref ? 2'h1 : 2'h2) : 2'h0;
      else
        gen_start <= {1'b0, gen_run};
      // RL22 exported status for option modules
      xfer_cmd    <= xfer_done;
      retx_cmd    <= retx_done;
      backup_fail <= gen_run && !alt_av;
      src_avail   <= {src2_ok, avail[0]};
      // RL20 source lamps
      lamps.src1_av <= avail[0];
      lamps.src2_av <= src2_ok;
      // RL19 run lamp, RL16 stop timing lamp
      lamps.gen_run     <= gen_run;
      lamps.stop_timing <= (state == ats_seq_pkg::ST_STOP);
      lamps.retx_timing <= (state == ats_seq_pkg::ST_RETX);
      lamps.retx_done   <= retx_done;
      lamps.xfer_timing <= (state == ats_seq_pkg::ST_XFER) && alt_av;
      lamps.xfer_done   <= xfer_done;
    end
  end

  // RL5 RL6 RL7 trip points handed to the front end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) thresh <= '0;
    else begin
      thresh.uv_pick  <= sense_cfg[7:0];
      thresh.uv_drop  <= sense_cfg[15:8];
      thresh.ov_limit <= sense_cfg[23:16];
      thresh.ov_pick  <= sense_cfg[23:16] - 8'(`OV_PICK_GAP);
      thresh.fr_pick  <= sense_cfg[31:24];
      thresh.fr_drop  <= sense_cfg[31:24] + 8'(`FR_DROP_WIDE);
    end
  end

  // APB: zero wait states, settings clamped into range on write
  assign wr     = psel & penable & pwrite;
  assign pready = 1'b1;
  assign rd_hit = (paddr == `OFS_CTRL) || (paddr == `OFS_SENSE) ||
                  (paddr == `OFS_DLY_A) || (paddr == `OFS_DLY_B) ||
                  (paddr == `OFS_STATUS);
  assign pslverr = psel & penable & !rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= `RST_CTRL;
      sense_cfg <= `RST_SENSE;
      dly_a     <= `RST_DLY_A;
      dly_b     <= `RST_DLY_B;
    end else if (wr) begin
      case (paddr)
        `OFS_CTRL: ctrl <= {25'h0, pwdata[6:0]};
        // RL5 RL6 RL7 setting ranges
        `OFS_SENSE: sense_cfg <= {
          clamp8(pwdata[31:24], `FR_BAND_MIN, `FR_BAND_MAX),
          clamp8(pwdata[23:16], `OV_LIM_MIN, `OV_LIM_MAX),
          clamp8(pwdata[15:8], `UV_DROP_MIN, `UV_DROP_MAX),
          clamp8(pwdata[7:0], `UV_PICK_MIN, `UV_PICK_MAX)};
        // RL8 RL9 RL10 RL12 delay ranges
        `OFS_DLY_A: dly_a <= {
          clamp8(pwdata[31:24], 0, `FR_DLY_MAX_S),
          clamp8(pwdata[23:16], 0, `OV_DLY_MAX_S),
          clamp8(pwdata[15:8], 0, `XFER_MAX_S),
          clamp8(pwdata[7:0], 0,
                 ctrl[`F_EXT_START] ? `START_EXT_S : `START_MAX_S)};
        // RL14 RL15 delay ranges
        `OFS_DLY_B: dly_b <= {
          6'h0, (int'(pwdata[25:16]) > `STOP_MAX_S) ?
                10'(`STOP_MAX_S) : pwdata[25:16],
          5'h0, (int'(pwdata[10:0]) > `RETX_MAX_S) ?
                11'(`RETX_MAX_S) : pwdata[10:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_CTRL:   prdata <= ctrl;
        `OFS_SENSE:  prdata <= sense_cfg;
        `OFS_DLY_A:  prdata <= dly_a;
        `OFS_DLY_B:  prdata <= dly_b;
        `OFS_STATUS: prdata <= {15'h0, state, lamps, src2_ok, avail};
        default:     prdata <= 32'h0;
      endcase
    end
  end

  a_avail_pickup: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(avail[0]) |-> $past(pick_ok[0])) // RL1
    else $error("source one latched without pickup");
  a_avail_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(avail[1]) |-> $past(drop_exp[1])) // RL2
    else $error("source two dropped before its delay");
  a_uv_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    dcond_all[0][0] && dcnt[0][0] < 16'h0005 |-> !drop_exp[0] ||
    dcond_all[0][1] || dcond_all[0][2]) // RL4
    else $error("undervoltage dropout before half a second");
  a_start_abort: assert property (@(posedge pclk) disable iff (!presetn)
    state == ats_seq_pkg::ST_START && nrm_av
    |=> state == ats_seq_pkg::ST_NORMAL && seq_cnt == '0) // RL9
    else $error("start delay not reset by source return");
  a_uu_no_delay: assert property (@(posedge pclk) disable iff (!presetn)
    state == ats_seq_pkg::ST_START && !nrm_av &&
    mode == ats_seq_pkg::MODE_UTIL_UTIL
    |=> state == ats_seq_pkg::ST_XFER) // RL11
    else $error("start delay applied between utilities");
  a_xfer_done: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(xfer_done) |-> $past(state == ats_seq_pkg::ST_XFER && seq_exp)
    ##1 lamps.xfer_done && !lamps.xfer_timing) // RL18
    else $error("transfer complete without expiry");
  a_instant_retx: assert property (@(posedge pclk) disable iff (!presetn)
    state == ats_seq_pkg::ST_RETX && nrm_av && pin_s[1]
    |=> state == ats_seq_pkg::ST_STOP ##1 lamps.retx_done) // RL24
    else $error("instant retransfer did not skip delay");
  a_stop_lamps: assert property (@(posedge pclk) disable iff (!presetn)
    state == ats_seq_pkg::ST_STOP && next_state == ats_seq_pkg::ST_NORMAL
    |=> ##1 !lamps.gen_run && !lamps.stop_timing && gen_start == 2'h0)
    // RL16
    else $error("stop expiry left run indication on");
  a_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
    pin_s[0] |=> !lamps.src2_av) // RL23
    else $error("source two shown available while inhibited");
  a_run_lamp: assert property (@(posedge pclk) disable iff (!presetn)
    lamps.gen_run == (gen_start != 2'h0)) // RL19
    else $error("run lamp disagrees with start output");
endmodule : ats_seq

// ---- hdl/ats_seq_cfg.svh ----
// Constants for the transfer switch sequencer: offsets, resets, timing
`ifndef ATS_SEQ_CFG_SVH
`define ATS_SEQ_CFG_SVH
// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_SENSE     8'h04
`define OFS_DLY_A     8'h08
`define OFS_DLY_B     8'h0c
`define OFS_STATUS    8'h10
// Reset values
`define RST_CTRL      32'h0000_0070
`define RST_SENSE     32'h0a_69_5a_5a
`define RST_DLY_A     32'h05_0a_05_03
`define RST_DLY_B     32'h0078_012c
// Field positions
`define F_MODE_LO     0
`define F_EXT_START   2
`define F_ONE_PHASE   3
`define F_EN_LO       4
`define F_START_LO    0
`define F_XFER_LO     8
`define F_OV_LO       16
`define F_FR_LO       24
`define F_RETX_LO     0
`define F_STOP_LO     16
// Setting limits, percent and seconds
`define UV_PICK_MIN   85
`define UV_PICK_MAX   100
`define UV_DROP_MIN   75
`define UV_DROP_MAX   98
`define OV_LIM_MIN    105
`define OV_LIM_MAX    135
`define OV_PICK_GAP   5
`define FR_BAND_MIN   5
`define FR_BAND_MAX   20
`define FR_DROP_WIDE  5
`define OV_DLY_MAX_S  120
`define FR_DLY_MAX_S  15
`define START_MAX_S   15
`define START_EXT_S   90
`define XFER_MAX_S    120
`define RETX_MAX_S    1800
`define STOP_MAX_S    600
// Timing
`define CLK_PERIOD_NS 8
`define TICK_NS       100000000
`define TICK_CYC      (`TICK_NS / `CLK_PERIOD_NS)
`define TICKS_PER_S   (1000000000 / `TICK_NS)
`define UV_DROP_MS    500
`define UV_DROP_TICKS (`UV_DROP_MS * 1000000 / `TICK_NS)
`endif

// ---- hdl/ats_seq_pkg.sv ----
// Types shared by the transfer switch sequencer
package ats_seq_pkg;
  typedef enum logic [1:0] {
    MODE_UTIL_GEN  = 2'h0,
    MODE_UTIL_UTIL = 2'h1,
    MODE_GEN_GEN   = 2'h2
  } mode_t;

  typedef enum logic [5:0] {
    ST_NORMAL = 6'h01,
    ST_START  = 6'h02,
    ST_XFER   = 6'h04,
    ST_ALT    = 6'h08,
    ST_RETX   = 6'h10,
    ST_STOP   = 6'h20
  } state_t;

  // Comparator flags for one source from the analog front end
  typedef struct packed {
    logic [2:0] uv_above_pick;
    logic [2:0] uv_below_drop;
    logic       ov_below_pick;
    logic       ov_over;
    logic       fr_in_pick;
    logic       fr_out_drop;
  } sense_t;

  typedef struct packed {
    logic src1_av;
    logic src2_av;
    logic gen_run;
    logic stop_timing;
    logic retx_timing;
    logic retx_done;
    logic xfer_timing;
    logic xfer_done;
  } lamp_t;

  // Trip points handed back to the analog front end, in percent
  typedef struct packed {
    logic [7:0] uv_pick;
    logic [7:0] uv_drop;
    logic [7:0] ov_limit;
    logic [7:0] ov_pick;
    logic [7:0] fr_pick;
    logic [7:0] fr_drop;
  } thresh_t;
endpackage : ats_seq_pkg

// ---- verif/gen_set_model.sv ----
// Generator set and second supply model: source two flags follow the run or the second utility
`timescale 1ns/1ps
module gen_set_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Run command from the sequencer, second utility present
  input  wire logic [1:0] gen_start,
  input  wire logic       utility2,
  // Source two comparator flags
  output ats_seq_pkg::sense_t src
);
  localparam ats_seq_pkg::sense_t GOOD = 10'h38a;
  localparam ats_seq_pkg::sense_t BAD  = 10'h075;
  logic [4:0] warm;

  // Voltage builds only after the engine has run, or the second utility has been present, for a while
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm <= 5'h00;
      src  <= BAD;
    end else if (!(|gen_start) && !utility2) begin
      warm <= 5'h00;
      src  <= BAD;
    end else if (warm != 5'h10) begin
      warm <= warm + 5'h01;
    end else begin
      src <= GOOD;
    end
  end
endmodule : gen_set_model

// ---- verif/tb_ats_seq.sv ----
// Self-checking bench for the transfer switch sequencer
`timescale 1ns/1ps
`include "ats_seq_cfg.svh"
module tb_ats_seq;
  localparam logic [9:0] GOOD = 10'h38a;
  localparam logic [9:0] TWO  = 10'h18a;
  localparam logic [9:0] LOW1 = 10'h31a;
  localparam logic [9:0] FRQ  = 10'h389;
  logic                      pclk, presetn, psel, penable, pwrite;
  logic                      inhibit_open, instant_retx, pref_sel, utility2;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata;
  logic                      pready, pslverr, xfer_cmd, retx_cmd, backup_fail;
  logic [1:0]                gen_start, src_avail;
  ats_seq_pkg::sense_t       s1, s2;
  ats_seq_pkg::sense_t [1:0] sense_w;
  ats_seq_pkg::lamp_t        lamps;
  ats_seq_pkg::thresh_t      thresh;
  logic [14:0]               obs;
  logic [96:0]               note_q[$];
  logic [32:0]               rd_q[$];
  logic [96:0]               nt;
  logic [47:0]               got;
  int                        fail_count, checked, seed;

  assign sense_w = {s2, s1};
  assign obs = {gen_start, xfer_cmd, retx_cmd, backup_fail, src_avail, lamps};

  ats_seq #(.TICK_CYCLES(4)) ats_seq_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense_in(sense_w),
    .inhibit_open(inhibit_open), .instant_retx(instant_retx),
    .pref_sel(pref_sel), .gen_start(gen_start), .xfer_cmd(xfer_cmd),
    .retx_cmd(retx_cmd), .backup_fail(backup_fail), .src_avail(src_avail),
    .lamps(lamps), .thresh(thresh));
  gen_set_model gen_set_model_i (
    .pclk(pclk), .presetn(presetn), .gen_start(gen_start),
    .utility2(utility2), .src(s2));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic miss(input string m);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : miss

  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // Read results are judged at the edge that ends the access
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      checked++;
      if (rd_q.size() == 0)
        miss("read result with no note");
      else if ({pslverr, prdata} !== rd_q.pop_front())
        miss("read data or error flag differs");
    end
  end

  // Port notes are judged mid-cycle, once the outputs have settled
  always @(negedge pclk) begin
    while (note_q.size() > 0) begin
      nt = note_q.pop_front();
      got = nt[96] ? thresh : {33'h0, obs};
      checked++;
      if ((got & nt[95:48]) !== nt[47:0])
        miss("output pattern differs");
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic look(input logic [14:0] m, input logic [14:0] e);
    note_q.push_back({1'b0, 33'h0, m, 33'h0, e});
  endtask : look

  task automatic wait_obs(input int b, input logic v, input int mx);
    int n;
    n = 0;
    while (obs[b] !== v && n < mx) begin
      @(negedge pclk);
      n++;
    end
    checked++;
    if (obs[b] !== v)
      miss("output bit late");
    // Leave on a rising edge so a following note cannot race the checker
    @(posedge pclk);
  endtask : wait_obs

  task automatic src(input logic [9:0] v);
    @(posedge pclk);
    s1 <= v;
  endtask : src

  initial begin
    seed = 32'h0bf84e5f;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {inhibit_open, instant_retx, pref_sel, utility2} = 4'h0;
    s1 = 10'h075;
    presetn = 1'b0;
    cyc(6);
    presetn <= 1'b1;
    rd(`OFS_CTRL, {1'b0, `RST_CTRL});
    rd(`OFS_SENSE, {1'b0, `RST_SENSE});
    rd(`OFS_DLY_A, {1'b0, `RST_DLY_A});
    rd(`OFS_DLY_B, {1'b0, `RST_DLY_B});
    look(15'h7fff, 15'h0000);
    rd(8'h14, {1'b1, 32'h0});
    apb(1'b1, `OFS_SENSE, 32'h0);
    rd(`OFS_SENSE, {1'b0, 32'h05694b55});
    note_q.push_back({1'b1, 48'hff00ffffffff, 48'h55006964050a});
    apb(1'b1, `OFS_SENSE, 32'hffffffff);
    rd(`OFS_SENSE, {1'b0, 32'h14876264});
    apb(1'b1, `OFS_SENSE, `RST_SENSE);
    apb(1'b1, `OFS_DLY_A, 32'h000001c8);
    rd(`OFS_DLY_A, {1'b0, 32'h0000010f});
    apb(1'b1, `OFS_CTRL, 32'h00000074);
    apb(1'b1, `OFS_DLY_A, 32'h000001c8);
    rd(`OFS_DLY_A, {1'b0, 32'h0000015a});
    apb(1'b1, `OFS_CTRL, 32'h00000070);
    apb(1'b1, `OFS_DLY_A, 32'h00000101);
    apb(1'b1, `OFS_DLY_B, 32'hffffffff);
    rd(`OFS_DLY_B, {1'b0, 32'h02580708});
    apb(1'b1, `OFS_DLY_B, 32'h00010001);
    src(TWO);
    cyc(40);
    look(15'h0100, 15'h0000);
    src(GOOD);
    wait_obs(8, 1'b1, 30);
    look(15'h0180, 15'h0180);
    // Short dips must not reach the available flag
    repeat (4) begin
      src(LOW1);
      pref_sel <= 1'($random(seed));
      cyc(1 + ($random(seed) & 7));
      src(GOOD);
      cyc(30);
      look(15'h0100, 15'h0100);
    end
    src(LOW1);
    pref_sel <= 1'b0;
    cyc(12);
    look(15'h0100, 15'h0100);
    wait_obs(8, 1'b0, 20);
    cyc(30);
    look(15'h2000, 15'h0000);
    wait_obs(13, 1'b1, 30);
    look(15'h0020, 15'h0020);
    wait_obs(9, 1'b1, 60);
    look(15'h0003, 15'h0002);
    cyc(30);
    look(15'h1000, 15'h0000);
    wait_obs(12, 1'b1, 30);
    look(15'h0843, 15'h0041);
    src(GOOD);
    wait_obs(8, 1'b1, 30);
    look(15'h000c, 15'h0008);
    cyc(30);
    look(15'h0800, 15'h0000);
    wait_obs(11, 1'b1, 30);
    look(15'h003c, 15'h0034);
    cyc(30);
    look(15'h2000, 15'h2000);
    wait_obs(13, 1'b0, 30);
    look(15'h0030, 15'h0000);
    src(LOW1);
    instant_retx <= 1'b1;
    wait_obs(12, 1'b1, 200);
    look(15'h0800, 15'h0000);
    src(GOOD);
    wait_obs(8, 1'b1, 30);
    wait_obs(11, 1'b1, 8);
    wait_obs(13, 1'b0, 60);
    apb(1'b1, `OFS_CTRL, 32'h00000071);
    instant_retx <= 1'b0;
    utility2 <= 1'b1;
    wait_obs(9, 1'b1, 60);
    cyc(1);
    inhibit_open <= 1'b1;
    wait_obs(9, 1'b0, 8);
    look(15'h0040, 15'h0000);
    cyc(1);
    inhibit_open <= 1'b0;
    wait_obs(9, 1'b1, 30);
    src(FRQ);
    wait_obs(8, 1'b0, 12);
    wait_obs(13, 1'b1, 6);
    cyc(5);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miss("watchdog expired");
    wrap_up();
  end
endmodule : tb_ats_seq
